// [bcfg_pkg.sv]
// package for the bridge configuration header and command decode block
package bcfg_pkg;
  localparam logic [9:0]  IDENT_DW_OFF       = 10'h000;  // byte 0x000 vendor id, 0x002 device id
  localparam logic [11:0] VENDOR_ID_BYTE_OFF = 12'h000;
  localparam logic [11:0] DEVICE_ID_BYTE_OFF = 12'h002;
  localparam logic [9:0]  COMMAND_DW_OFF     = 10'h001;  // byte 0x004
  localparam logic [11:0] COMMAND_BYTE_OFF   = 12'h004;
  localparam int          IO_EN_BIT          = 0;
  localparam int          MEM_EN_BIT         = 1;
  localparam int          MASTER_EN_BIT      = 2;
  localparam int          SPECIAL_CYC_BIT    = 3;
  localparam int          WR_INVAL_BIT       = 4;
  localparam logic [15:0] COMMAND_RESET      = 16'h0000;
  localparam logic [15:0] COMMAND_WR_MASK    = 16'h0007;
  localparam logic [31:0] RDATA_RESET        = 32'h0000_0000;

  typedef enum logic [1:0] {
    BCFG_KIND_MEM,
    BCFG_KIND_IO,
    BCFG_KIND_OTHER,
    BCFG_KIND_CPL
  } bcfg_kind_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [9:0]  dw_addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } bcfg_cfg_req_t;

  typedef struct packed {
    logic        ack;
    logic        hit;
    logic [31:0] rdata;
  } bcfg_cfg_rsp_t;

  typedef struct packed {
    logic        valid;
    bcfg_kind_t  kind;
    logic        posted;
    logic [31:0] addr;
  } bcfg_tlp_t;

  typedef struct packed {
    logic [31:0] io_base;
    logic [31:0] io_limit;
    logic [31:0] mem_base;
    logic [31:0] mem_limit;
    logic [31:0] pref_base;
    logic [31:0] pref_limit;
  } bcfg_windows_t;

  typedef struct packed {
    logic forward;
    logic ur;
    logic ur_cpl;
  } bcfg_up_dec_t;
endpackage

// [bcfg_window_match.sv]
// inclusive base/limit address window compare
`timescale 1ns/10ps
`default_nettype none
module bcfg_window_match (
  input  wire logic [31:0] addr,   // request address
  input  wire logic [31:0] base,   // lowest address in window
  input  wire logic [31:0] limit,  // highest address in window
  output logic             in_window  // address falls in window
);
  // an empty window (base above limit) never matches
  assign in_window = (addr >= base) && (addr <= limit);
endmodule
`default_nettype wire

// [bcfg_header.sv]
// type 1 header identification and command bits, with window claim and upstream gating
// Behaviour
// - io_space_enable low: ignore primary io accesses in io window; high enables decoding.
// - memory_space_enable low: do not claim memory or prefetchable window accesses.
// - bus_master_enable low: do not forward subordinate memory, io, msi requests; treat as UR.
// - bus_master_enable low: every upstream non-posted memory or io request gets a UR completion.
// - bus_master_enable never affects completions or non memory, non io requests.
// - special_cycle_enable and write_invalidate_enable are read-only zero.
// - read-only 16-bit vendor_identification at offset 0, bits 15:0.
// - read-only 16-bit device_identification at offset 2.
`timescale 1ns/10ps
`default_nettype none
module bcfg_header #(
  parameter logic [15:0] VENDOR_ID = 16'h5a5a,  // arbitrary value
  parameter logic [15:0] DEVICE_ID = 16'h0c3e   // arbitrary value
) (
  input  wire logic                    clk_sys,        // core clock, 20 MHz
  input  wire logic                    rst,            // async reset, active high
  input  wire bcfg_pkg::bcfg_cfg_req_t cfg_req,        // configuration access from upstream
  output var  bcfg_pkg::bcfg_cfg_rsp_t cfg_rsp,        // configuration answer
  input  wire bcfg_pkg::bcfg_windows_t windows,        // window bases and limits
  input  wire bcfg_pkg::bcfg_tlp_t     down_req,       // primary-bus request to classify
  output logic                         down_claim,     // request claimed by a window, pulse
  input  wire bcfg_pkg::bcfg_tlp_t     up_req,         // request or completion from below
  output logic                         up_valid,       // decision valid, pulse
  output var  bcfg_pkg::bcfg_up_dec_t  up_dec,         // forward, UR, UR completion
  output logic [15:0]                  bridge_command  // current command value
);
  logic [15:0]             cmd_q;
  logic [15:0]             cmd_d;
  bcfg_pkg::bcfg_cfg_rsp_t rsp_q;
  bcfg_pkg::bcfg_cfg_rsp_t rsp_d;
  logic                    claim_q;
  logic                    claim_d;
  logic                    upv_q;
  logic                    upv_d;
  bcfg_pkg::bcfg_up_dec_t  dec_q;
  bcfg_pkg::bcfg_up_dec_t  dec_d;
  logic                    in_io;
  logic                    in_mem;
  logic                    in_pref;
  logic [31:0]             cmd_word;
  logic [31:0]             cmd_merge;

  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  bcfg_window_match u_io (
    .addr   (down_req.addr),
    .base   (windows.io_base),
    .limit  (windows.io_limit),
    .in_window (in_io)
  );
  bcfg_window_match u_mem (
    .addr   (down_req.addr),
    .base   (windows.mem_base),
    .limit  (windows.mem_limit),
    .in_window (in_mem)
  );
  bcfg_window_match u_pref (
    .addr   (down_req.addr),
    .base   (windows.pref_base),
    .limit  (windows.pref_limit),
    .in_window (in_pref)
  );

  // status half of the command dword is outside this block and reads zero
  assign cmd_word = {16'h0000, cmd_q};

  // configuration register file; a write answers with the word from before the write,
  // so software doing read-modify-write sees one consistent old value
  always_comb begin
    cmd_d       = cmd_q;
    // only enable bits take writes; the rest hold their constant value
    cmd_merge   = merge_be(cmd_word, cfg_req.wdata, cfg_req.be) & {16'h0000, bcfg_pkg::COMMAND_WR_MASK};
    rsp_d       = '0;
    rsp_d.ack   = cfg_req.valid;
    if (cfg_req.valid) begin
      unique case (cfg_req.dw_addr)
        bcfg_pkg::IDENT_DW_OFF: begin
          rsp_d.hit   = 1'b1;
          rsp_d.rdata = {DEVICE_ID, VENDOR_ID};
        end
        bcfg_pkg::COMMAND_DW_OFF: begin
          rsp_d.hit   = 1'b1;
          rsp_d.rdata = cmd_word;
          if (cfg_req.write) begin
            cmd_d = cmd_merge[15:0];
          end
        end
        default: begin
          // unmapped: completes with zero data and no effect
          rsp_d.hit   = 1'b0;
          rsp_d.rdata = bcfg_pkg::RDATA_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_q <= bcfg_pkg::COMMAND_RESET;
      rsp_q <= '0;
    end else begin
      cmd_q <= cmd_d;
      rsp_q <= rsp_d;
    end
  end

  // primary-bus window claim; the enable is taken as it stands at the taking edge,
  // so a command write in the same cycle only affects the next request
  always_comb begin
    claim_d = 1'b0;
    if (down_req.valid) begin
      unique case (down_req.kind)
        bcfg_pkg::BCFG_KIND_IO: begin
          claim_d = cmd_q[bcfg_pkg::IO_EN_BIT] & in_io;
        end
        bcfg_pkg::BCFG_KIND_MEM: begin
          // memory and prefetchable windows share the one enable
          claim_d = cmd_q[bcfg_pkg::MEM_EN_BIT] & (in_mem | in_pref);
        end
        bcfg_pkg::BCFG_KIND_OTHER: begin
          claim_d = 1'b0;
        end
        bcfg_pkg::BCFG_KIND_CPL: begin
          claim_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      claim_q <= 1'b0;
    end else begin
      claim_q <= claim_d;
    end
  end

  // upstream gating by bus_master_enable; interrupt messages arrive as memory
  // writes, so they are held back together with ordinary memory requests
  always_comb begin
    upv_d = up_req.valid;
    dec_d = '0;
    if (up_req.valid) begin
      unique case (up_req.kind)
        bcfg_pkg::BCFG_KIND_MEM: begin
          if (cmd_q[bcfg_pkg::MASTER_EN_BIT]) begin
            dec_d.forward = 1'b1;
          end else begin
            dec_d.ur     = 1'b1;
            dec_d.ur_cpl = ~up_req.posted;
          end
        end
        bcfg_pkg::BCFG_KIND_IO: begin
          if (cmd_q[bcfg_pkg::MASTER_EN_BIT]) begin
            dec_d.forward = 1'b1;
          end else begin
            // posted requests are dropped as UR with no completion to send
            dec_d.ur     = 1'b1;
            dec_d.ur_cpl = ~up_req.posted;
          end
        end
        bcfg_pkg::BCFG_KIND_OTHER: begin
          // neither memory nor io: passes whatever the enable says
          dec_d.forward = 1'b1;
        end
        bcfg_pkg::BCFG_KIND_CPL: begin
          // completions are never gated, in either direction
          dec_d.forward = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upv_q <= 1'b0;
      dec_q <= '0;
    end else begin
      upv_q <= upv_d;
      dec_q <= dec_d;
    end
  end

  assign cfg_rsp        = rsp_q;
  assign down_claim     = claim_q;
  assign up_valid       = upv_q;
  assign up_dec         = dec_q;
  assign bridge_command = cmd_q;
endmodule
`default_nettype wire

// [bcfg_header_checker.sv]
// concurrent checks on the header block ports
`timescale 1ns/10ps
`default_nettype none
module bcfg_header_checker #(
  parameter logic [15:0] VENDOR_ID = 16'h5a5a,
  parameter logic [15:0] DEVICE_ID = 16'h0c3e
) (
  input wire logic                    clk_sys,       // core clock
  input wire logic                    rst,           // async reset
  input wire bcfg_pkg::bcfg_cfg_req_t cfg_req,       // config access
  input wire bcfg_pkg::bcfg_cfg_rsp_t cfg_rsp,       // config answer
  input wire bcfg_pkg::bcfg_tlp_t     down_req,      // primary request
  input wire logic                    down_claim,    // window claim
  input wire bcfg_pkg::bcfg_tlp_t     up_req,        // request from below
  input wire logic                    up_valid,      // decision strobe
  input wire bcfg_pkg::bcfg_up_dec_t  up_dec,        // decision
  input wire logic [15:0]             bridge_command // command value
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire rd0 = cfg_req.valid && !cfg_req.write && cfg_req.dw_addr == 10'h000;
  wire wr1 = cfg_req.valid && cfg_req.write && cfg_req.dw_addr == 10'h001 && cfg_req.be[0];
  // memory kind also carries the in-band interrupt writes
  wire blk = up_req.valid && !up_req.kind[1] && !bridge_command[2];
  a_cfg_ack: assert property (cfg_req.valid |=> cfg_rsp.ack) else $error("no ack");
  a_vendor_read: assert property (rd0 |=> cfg_rsp.rdata[15:0] == VENDOR_ID) else $error("vendor");
  a_device_read: assert property (rd0 |=> cfg_rsp.rdata[31:16] == DEVICE_ID) else $error("device");
  a_ro_zero: assert property (bridge_command[15:3] == 13'h0) else $error("ro bits");
  a_cmd_write: assert property (wr1 |=> bridge_command[2:0] == $past(cfg_req.wdata[2:0]))
    else $error("cmd");
  a_cmd_hold: assert property (!wr1 |=> $stable(bridge_command)) else $error("cmd changed");
  a_unmapped_read: assert property (cfg_req.valid && cfg_req.dw_addr > 10'h001
    |=> !cfg_rsp.hit && cfg_rsp.rdata == 32'h0) else $error("unmapped");
  a_io_gate: assert property (down_req.valid && down_req.kind == bcfg_pkg::BCFG_KIND_IO
    && !bridge_command[0] |=> !down_claim) else $error("io claim");
  a_mem_gate: assert property (down_req.valid && down_req.kind == bcfg_pkg::BCFG_KIND_MEM
    && !bridge_command[1] |=> !down_claim) else $error("mem claim");
  a_bme_block: assert property (blk |=> up_valid && up_dec.ur && !up_dec.forward
    && up_dec.ur_cpl != $past(up_req.posted)) else $error("bme block");
  a_other_fwd: assert property (up_req.valid && up_req.kind[1]
    |=> up_valid && up_dec.forward && !up_dec.ur) else $error("other fwd");
endmodule
bind bcfg_header bcfg_header_checker #(.VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID)) chk_inst (
  .clk_sys(clk_sys), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .down_req(down_req),
  .down_claim(down_claim), .up_req(up_req), .up_valid(up_valid), .up_dec(up_dec), .bridge_command(bridge_command));
`default_nettype wire

// [bcfg_sub_model.sv]
// subordinate-side source of requests and completions
`timescale 1ns/10ps
`default_nettype none
module bcfg_sub_model (
  input  wire logic          clk_sys, // core clock
  input  wire logic          en,      // allow traffic
  input  wire logic [31:0]   rnd,     // random word
  output var bcfg_pkg::bcfg_tlp_t up_req // toward the block
);
  initial up_req = '0;
  // launched off the falling edge so the block samples a settled value
  always @(negedge clk_sys) begin
    up_req.valid  <= en & rnd[0];
    up_req.kind   <= bcfg_pkg::bcfg_kind_t'(rnd[2:1]);
    up_req.posted <= rnd[3];
    up_req.addr   <= rnd;
  end
endmodule
`default_nettype wire

// [bcfg_tb.sv]
// self-checking bench for the header block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [15:0] VEN_CODE = 16'h3c71; // arbitrary value
  localparam logic [15:0] DEV_CODE = 16'h0e29; // arbitrary value
  localparam logic [31:0] PICK [8] = '{32'h0fff, 32'h1000, 32'h1fff, 32'h2000,
    32'h7fff_ffff, 32'h8fff_ffff, 32'h9000_0000, 32'ha000_0000};
  logic                    clk_sys, rst, en, down_claim, up_valid, pv, pp, pb, f;
  logic [31:0]             seed, rnd_up, rd;
  logic [15:0]             bridge_command;
  logic [2:0]              c;
  logic [1:0]              pk;
  int                      miscompares, n_checks;
  bcfg_pkg::bcfg_cfg_req_t cfg_req;
  bcfg_pkg::bcfg_cfg_rsp_t cfg_rsp;
  bcfg_pkg::bcfg_windows_t windows;
  bcfg_pkg::bcfg_tlp_t     down_req, up_req;
  bcfg_pkg::bcfg_up_dec_t  up_dec;
  bcfg_header #(.VENDOR_ID(VEN_CODE), .DEVICE_ID(DEV_CODE)) bcfg_header_inst (.clk_sys(clk_sys), .rst(rst),
    .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .windows(windows), .down_req(down_req), .down_claim(down_claim),
    .up_req(up_req), .up_valid(up_valid), .up_dec(up_dec), .bridge_command(bridge_command));
  bcfg_sub_model bcfg_sub_model_inst (.clk_sys(clk_sys), .en(en), .rnd(rnd_up), .up_req(up_req));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_claim(input bcfg_pkg::bcfg_tlp_t t, input logic [2:0] k);
    if (t.kind == bcfg_pkg::BCFG_KIND_IO) return k[0] && t.addr >= 32'h1000 && t.addr <= 32'h1fff;
    if (t.kind == bcfg_pkg::BCFG_KIND_MEM) return k[1] && (t.addr[31:28] == 4'h8 || t.addr[31:28] == 4'ha);
    return 1'b0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cfg(input logic wr, input logic [9:0] dw, input logic [3:0] be, input logic [31:0] wd, input logic hit);
    @(negedge clk_sys);
    cfg_req = '{1'b1, wr, dw, be, wd};
    @(negedge clk_sys);
    chk({30'h0, cfg_rsp.ack, cfg_rsp.hit}, {30'h0, 1'b1, hit});
    rd = cfg_rsp.rdata;
    cfg_req.valid = 1'b0;
  endtask
  task automatic down(input logic [31:0] r);
    @(negedge clk_sys);
    down_req = '{1'b1, bcfg_pkg::bcfg_kind_t'(r[4:3]), r[5], PICK[r[2:0]]};
    @(negedge clk_sys);
    chk({31'h0, down_claim}, {31'h0, exp_claim(down_req, c)});
    down_req.valid = 1'b0;
  endtask
  always @(negedge clk_sys) rnd_up <= lfsr(rnd_up);
  // enable bit as seen at the taking edge, before any write there lands
  always @(posedge clk_sys) {pv, pk, pp, pb} <= {up_req.valid, up_req.kind, up_req.posted, bridge_command[2]};
  always @(negedge clk_sys) if (!rst) begin
    f = pk[1] | pb;
    chk({28'h0, up_valid, up_dec}, {28'h0, pv, pv & f, pv & !f, pv & !f & !pp});
  end
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    rst = 1'b1;
    en = 1'b0;
    c = 3'h0;
    seed = 32'hdfc0ed5a;
    rnd_up = seed;
    cfg_req = '0;
    down_req = '0;
    windows = '{32'h1000, 32'h1fff, 32'h8000_0000, 32'h8fff_ffff, 32'ha000_0000, 32'hafff_ffff};
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    en = 1'b1;
    cfg(1'b0, 10'h001, 4'h0, 32'h0, 1'b1);
    chk(rd, 32'h0);
    cfg(1'b1, 10'h000, 4'hf, seed, 1'b1);
    cfg(1'b0, 10'h000, 4'h0, 32'h0, 1'b1);
    chk(rd, {DEV_CODE, VEN_CODE});
    cfg(1'b1, 10'h001, 4'hf, 32'hffff_ffff, 1'b1);
    c = 3'h7;
    cfg(1'b0, 10'h001, 4'h0, 32'h0, 1'b1);
    chk(rd, 32'h7);
    cfg(1'b0, 10'h3a5, 4'h0, 32'h0, 1'b0);
    chk(rd, 32'h0);
    for (int i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      if (seed[7:5] == 3'h0) begin
        cfg(1'b1, 10'h001, {3'h0, seed[11]}, {29'h0, seed[10:8]}, 1'b1);
        if (seed[11]) c = seed[10:8];
      end else down(seed);
    end
    wrap_up;
  end
endmodule
`default_nettype wire
